// file: shared/asc_pkg.sv
// Constants, field layout and carrier types of the converter sequencer control block
package asc_pkg;

   // Word offsets on the register bus
   localparam logic [7:0] ASC_OFS_CTRL   = 8'h00;
   localparam logic [7:0] ASC_OFS_STAT2  = 8'h04;
   localparam logic [7:0] ASC_OFS_CHSEL  = 8'h08;
   localparam logic [7:0] ASC_OFS_RESULT = 8'h0C;
   localparam logic [7:0] ASC_OFS_DMACFG = 8'h10;
   localparam logic [7:0] ASC_OFS_CHDATA = 8'h80;

   // Bit positions in the control word (high byte and low byte)
   localparam int ASC_BIT_BUSY   = 15;
   localparam int ASC_BIT_INT    = 14;
   localparam int ASC_BIT_CONV_DONE_IRQ_ENABLE   = 13;
   localparam int ASC_BIT_PAUSE_FLAG   = 12;
   localparam int ASC_BIT_STS_HI = 11;
   localparam int ASC_BIT_STS_LO = 10;
   localparam int ASC_BIT_SOFT_START   = 9;
   localparam int ASC_BIT_RSVD   = 8;
   localparam int ASC_BIT_MD_HI  = 7;
   localparam int ASC_BIT_MD_LO  = 6;
   localparam int ASC_BIT_RES8   = 5;
   localparam int ASC_BIT_CHANNEL_READBACK_MODE  = 0;

   // Bit positions in the secondary status word
   localparam int ASC_BIT_SCANF  = 9;
   localparam int ASC_BIT_SCANIE = 8;

   // Bit positions in the start / end channel word and the DMA word
   localparam int ASC_BIT_STARTCH = 8;
   localparam int ASC_BIT_ENDCH   = 0;
   localparam int ASC_BIT_DMA_CONV = 0;
   localparam int ASC_BIT_DMA_SCAN = 1;

   // Operating mode codes
   localparam logic [1:0] ASC_MODE_SINGLE1 = 2'h0;
   localparam logic [1:0] ASC_MODE_SINGLE2 = 2'h1;
   localparam logic [1:0] ASC_MODE_CONT    = 2'h2;
   localparam logic [1:0] ASC_MODE_STOP    = 2'h3;

   // Values after reset
   localparam logic [1:0] ASC_RST_MODE  = 2'h0;
   localparam logic [1:0] ASC_RST_STS   = 2'h0;
   localparam logic [4:0] ASC_RST_CHAN  = 5'h00;
   localparam logic [9:0] ASC_RST_DATA  = 10'h000;
   localparam logic [1:0] ASC_RST_DMA   = 2'h0;

   // Sequencer states
   typedef enum logic [1:0] {ST_IDLE, ST_CONV, ST_HOLD, ST_WAIT} asc_state_e;

   // Request towards the analog converter
   typedef struct packed {
      logic       start;
      logic [4:0] chan;
      logic       eightBit;
   } asc_conv_req_s;

   // Answer from the analog converter
   typedef struct packed {
      logic       valid;
      logic [9:0] data;
   } asc_result_s;

endpackage

// file: hw/asc_trig_detect.sv
// Hardware activation detector: external pin falling edge and reload timer rising edge
`timescale 1ns/1ps
module asc_trig_detect (
   input  wire logic       ref_clk,
   input  wire logic       reset,
   input  wire logic       extTrigPin,
   input  wire logic       reloadTimer7Out,
   input  wire logic [1:0] startSource,
   output logic            hwActivation
);
   import asc_pkg::*;

   logic gatedExt;
   logic gatedTimer;
   logic extPrev_r;
   logic timerPrev_r;

   // Disabled sources look idle; enabling the pin while low gives an edge
   assign gatedExt   = extTrigPin | ~startSource[0];     // R15 R16
   assign gatedTimer = reloadTimer7Out & startSource[1]; // R15 R17

   // Previous levels for edge detection
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         extPrev_r   <= 1'b1;
         timerPrev_r <= 1'b0;
      end else begin
         extPrev_r   <= gatedExt;
         timerPrev_r <= gatedTimer;
      end
   end

   // First edge from any enabled source activates
   assign hwActivation = (extPrev_r & ~gatedExt) | (~timerPrev_r & gatedTimer); // R15 R16 R17
endmodule

// file: hw/asc_chan_step.sv
// Channel pointer stepping between start and end channel
`timescale 1ns/1ps
module asc_chan_step (
   input  wire logic [4:0] curChan,
   input  wire logic [4:0] startChan,
   input  wire logic [4:0] endChan,
   output logic [4:0]      nextChan,
   output logic            lastChan
);
   import asc_pkg::*;

   logic [4:0] plusOne;

   // Five-bit sum wraps from 31 to 0 when start exceeds end
   assign plusOne  = curChan + 5'h01;                     // R25
   assign lastChan = (curChan == endChan);
   assign nextChan = lastChan ? startChan : plusOne;      // R21
endmodule

// file: hw/asc_seq_ctrl.sv
// Converter sequencer control and status with a classic Wishbone register slave
//
// The implementer's own choices: the Wishbone interface to the registers and the register offsets.
`timescale 1ns/1ps
//
// Function
// (R1) Secondary status bits 15:12 mirror busy, done flag, done enable, pause; read only.
// (R2) Secondary status bits 11 and 10 always read zero.
// (R3) Scan flag sets when the end channel result is stored.
// (R4) Continuous mode with scan enable raises scan interrupt or scan DMA request.
// (R5) Scan flag: cleared by DMA end or zero write, reads one in RMW.
// (R6) Protection guards common result, or channel results in continuous scan mode.
// (R7) Busy sets on activation, clears at single completion, else on zero write.
// (R8) Zero written to busy during conversion forces the sequence to stop.
// (R9) Software never stops and starts in one access; clears flags only when halted.
// (R10) Done flag sets on each common store; raises interrupt or DMA; DMA end clears.
// (R11) Store withheld and conversion halted while protected result unread.
// (R12) Continuous scan mode: pause when start channel ready and scan flag pending.
// (R13) Otherwise pause when any channel ready and done flag pending.
// (R14) Pause clears only by zero write or reset; not while DMA waits.
// (R15) Start source field adds external trigger and timer to software start.
// (R16) External trigger acts on falling edges, including when enabled while low.
// (R17) Timer activation comes from reload timer seven.
// (R18) Start bit one begins conversion; repeats restart only where mode allows.
// (R19) Software writes zero to the reserved control bit.
// (R20) Mode field: single with restart, single, continuous, stop; latter ignore reactivation.
// (R21) Single runs once, continuous repeats, stop waits per channel, forced stop restarts.
// (R22) Resolution bit one gives eight-bit results in the low byte.
// (R23) Channel number reads current pointer or latched previous channel; writes ignored.
// (R24) Readback mode bit is write only; reads return channel number bit zero.
// (R25) Start above end runs to channel 31, wraps to 0, ends at end.
module asc_seq_ctrl (
   input  wire logic                   ref_clk,
   input  wire logic                   reset,
   input  wire logic                   wb_cyc_i,
   input  wire logic                   wb_stb_i,
   input  wire logic                   wb_we_i,
   input  wire logic                   wb_lock_i,
   input  wire logic [7:0]             wb_adr_i,
   input  wire logic [3:0]             wb_sel_i,
   input  wire logic [31:0]            wb_dat_i,
   output logic [31:0]                 wb_dat_o,
   output logic                        wb_ack_o,
   input  wire logic                   extTrigPin,
   input  wire logic                   reloadTimer7Out,
   output asc_pkg::asc_conv_req_s      convReq,
   input  wire asc_pkg::asc_result_s   convResult,
   input  wire logic                   dmaConvDone,
   input  wire logic                   dmaScanDone,
   input  wire logic                   dmaPending,
   output logic                        convIrq,
   output logic                        convDmaReq,
   output logic                        scanIrq,
   output logic                        scanDmaReq
);
   import asc_pkg::*;

   // Bus access decoding: hit on a word offset with a given byte lane
   function automatic logic laneHit(input logic [7:0] adr, input logic [7:0] ofs,
                                    input logic [3:0] sel, input int lane);
      laneHit = (adr == ofs) && sel[lane];
   endfunction

   logic              ack_r;
   logic              wbReq;
   logic              wrEn;
   logic              rdEn;
   logic              wrCtrlLo;
   logic              wrCtrlHi;
   logic              wrStat2;
   logic              wrStartCh;
   logic              wrEndCh;
   logic              wrDma;

   logic              busy_r;
   logic              convFlag_r;
   logic              convIe_r;
   logic              pause_r;
   logic [1:0]        startSource_r;
   logic              rsvd_r;
   logic [1:0]        opMode_r;
   logic              res8_r;
   logic              achMode_r;
   logic              scanFlag_r;
   logic              scanIe_r;
   logic [1:0]        dmaCfg_r;
   logic [4:0]        startCh_r;
   logic [4:0]        endCh_r;
   logic [9:0]        result_r;
   logic [9:0]        chData_r [0:31];
   logic [4:0]        chPtr_r;
   logic [4:0]        chLatch_r;
   logic              launch_r;
   asc_state_e        state_r;

   asc_state_e        state_nxt;
   logic [4:0]        chPtr_nxt;
   logic              launch_nxt;
   asc_state_e        advState;
   logic [4:0]        advPtr;
   logic              advLaunch;

   logic              softStart;
   logic              busyClr;
   logic              hwActivation;
   logic              activation;
   logic              single1;
   logic              singleAny;
   logic              contMode;
   logic              protectChan;
   logic              blocked;
   logic              restart;
   logic              storeNow;
   logic              holdNow;
   logic [4:0]        stepNext;
   logic              stepLast;
   logic [9:0]        storeVal;
   logic [4:0]        achShown;
   logic              rmwRead;
   logic [15:0]       ctrlWord;
   logic [15:0]       stat2Word;

   // Wishbone classic slave: one wait state, ack for one cycle
   assign wbReq    = wb_cyc_i & wb_stb_i & ~ack_r;
   assign wrEn     = wbReq & wb_we_i;
   assign rdEn     = wbReq & ~wb_we_i;
   assign wb_ack_o = ack_r;

   always_ff @(posedge ref_clk) begin
      if (reset) begin
         ack_r <= 1'b0;
      end else begin
         ack_r <= wbReq;
      end
   end

   // Write strobes per byte lane
   assign wrCtrlLo  = wrEn & laneHit(wb_adr_i, ASC_OFS_CTRL, wb_sel_i, 0);
   assign wrCtrlHi  = wrEn & laneHit(wb_adr_i, ASC_OFS_CTRL, wb_sel_i, 1);
   assign wrStat2   = wrEn & laneHit(wb_adr_i, ASC_OFS_STAT2, wb_sel_i, 1);
   assign wrStartCh = wrEn & laneHit(wb_adr_i, ASC_OFS_CHSEL, wb_sel_i, 1);
   assign wrEndCh   = wrEn & laneHit(wb_adr_i, ASC_OFS_CHSEL, wb_sel_i, 0);
   assign wrDma     = wrEn & laneHit(wb_adr_i, ASC_OFS_DMACFG, wb_sel_i, 0);

   // Activation sources and mode decode
   assign softStart   = wrCtrlHi & wb_dat_i[ASC_BIT_SOFT_START];   // R18
   assign busyClr     = wrCtrlHi & ~wb_dat_i[ASC_BIT_BUSY];  // R8 R9
   assign activation  = softStart | hwActivation;            // R15
   assign single1     = (opMode_r == ASC_MODE_SINGLE1);
   assign singleAny   = single1 | (opMode_r == ASC_MODE_SINGLE2);
   assign contMode    = (opMode_r == ASC_MODE_CONT);
   assign protectChan = contMode & scanIe_r;                 // R6

   asc_trig_detect u_trig (
      .ref_clk         (ref_clk),
      .reset           (reset),
      .extTrigPin      (extTrigPin),
      .reloadTimer7Out (reloadTimer7Out),
      .startSource     (startSource_r),
      .hwActivation    (hwActivation)
   );

   asc_chan_step u_step (
      .curChan   (chPtr_r),
      .startChan (startCh_r),
      .endChan   (endCh_r),
      .nextChan  (stepNext),
      .lastChan  (stepLast)
   );

   // Protection: which pending request blocks the store
   assign blocked  = protectChan ? ((chPtr_r == startCh_r) & scanFlag_r)  // R6 R12
                                 : convFlag_r;                            // R6 R13
   assign restart  = (state_r == ST_CONV) & single1 & activation;         // R20
   assign storeNow = (((state_r == ST_CONV) & convResult.valid & ~restart)
                     | (state_r == ST_HOLD)) & ~blocked & ~busyClr;      // R11
   assign holdNow  = (state_r == ST_CONV) & convResult.valid & ~restart
                     & blocked & ~busyClr;                               // R11
   assign storeVal = res8_r ? {2'h0, convResult.data[9:2]} : convResult.data; // R22

   // Where the sequence goes after a stored result
   always_comb begin
      advState  = ST_CONV;
      advPtr    = stepNext;
      advLaunch = 1'b1;
      if (singleAny && stepLast) begin
         advState  = ST_IDLE;                                // R21 R7
         advPtr    = chPtr_r;
         advLaunch = 1'b0;
      end else if (opMode_r == ASC_MODE_STOP) begin
         advState  = ST_WAIT;                                // R21
         advLaunch = 1'b0;
      end
   end

   // Sequencer next state
   always_comb begin
      state_nxt  = state_r;
      chPtr_nxt  = chPtr_r;
      launch_nxt = 1'b0;
      case (state_r)
         ST_IDLE: begin
            if (activation) begin
               state_nxt  = ST_CONV;
               chPtr_nxt  = startCh_r;                       // R21
               launch_nxt = 1'b1;
            end
         end
         ST_CONV: begin
            if (restart) begin
               chPtr_nxt  = startCh_r;                       // R18 R20
               launch_nxt = 1'b1;
            end else if (convResult.valid && blocked) begin
               state_nxt = ST_HOLD;                          // R11
            end else if (convResult.valid) begin
               state_nxt  = advState;
               chPtr_nxt  = advPtr;
               launch_nxt = advLaunch;
            end
         end
         ST_HOLD: begin
            if (!blocked) begin
               state_nxt  = advState;                        // R11
               chPtr_nxt  = advPtr;
               launch_nxt = advLaunch;
            end
         end
         ST_WAIT: begin
            if (activation) begin
               state_nxt  = ST_CONV;                         // R21
               launch_nxt = 1'b1;
            end
         end
         default: begin
            state_nxt = ST_IDLE;
         end
      endcase
      if (busyClr) begin
         state_nxt  = ST_IDLE;                               // R8
         launch_nxt = 1'b0;
      end
   end

   // Sequencer registers; busy follows the sequence state
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         state_r  <= ST_IDLE;
         chPtr_r  <= ASC_RST_CHAN;
         launch_r <= 1'b0;
         busy_r   <= 1'b0;
      end else begin
         state_r  <= state_nxt;
         chPtr_r  <= chPtr_nxt;
         launch_r <= launch_nxt;
         busy_r   <= (state_nxt != ST_IDLE);                 // R7
      end
   end

   assign convReq = '{start: launch_r, chan: chPtr_r, eightBit: res8_r};

   // Control fields written by software
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         convIe_r      <= 1'b0;
         startSource_r <= ASC_RST_STS;
         rsvd_r        <= 1'b0;
         opMode_r      <= ASC_RST_MODE;
         res8_r        <= 1'b0;
         achMode_r     <= 1'b0;
         scanIe_r      <= 1'b0;
         dmaCfg_r      <= ASC_RST_DMA;
         startCh_r     <= ASC_RST_CHAN;
         endCh_r       <= ASC_RST_CHAN;
      end else begin
         if (wrCtrlHi) begin
            convIe_r      <= wb_dat_i[ASC_BIT_CONV_DONE_IRQ_ENABLE];
            startSource_r <= wb_dat_i[ASC_BIT_STS_HI:ASC_BIT_STS_LO]; // R15
            rsvd_r        <= wb_dat_i[ASC_BIT_RSVD];
         end
         if (wrCtrlLo) begin
            opMode_r  <= wb_dat_i[ASC_BIT_MD_HI:ASC_BIT_MD_LO];       // R20
            res8_r    <= wb_dat_i[ASC_BIT_RES8];                      // R22
            achMode_r <= wb_dat_i[ASC_BIT_CHANNEL_READBACK_MODE];                     // R24
         end
         if (wrStat2) begin
            scanIe_r <= wb_dat_i[ASC_BIT_SCANIE];
         end
         if (wrStartCh) begin
            startCh_r <= wb_dat_i[ASC_BIT_STARTCH +: 5];
         end
         if (wrEndCh) begin
            endCh_r <= wb_dat_i[ASC_BIT_ENDCH +: 5];
         end
         if (wrDma) begin
            dmaCfg_r <= wb_dat_i[1:0];
         end
      end
   end

   // Event flags: a set in the same cycle as a clear wins
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         convFlag_r <= 1'b0;
         scanFlag_r <= 1'b0;
         pause_r    <= 1'b0;
      end else begin
         if (storeNow) begin
            convFlag_r <= 1'b1;                                       // R10
         end else if (dmaConvDone || (wrCtrlHi && !wb_dat_i[ASC_BIT_INT])) begin
            convFlag_r <= 1'b0;                                       // R10
         end
         if (storeNow && stepLast) begin
            scanFlag_r <= 1'b1;                                       // R3
         end else if (dmaScanDone || (wrStat2 && !wb_dat_i[ASC_BIT_SCANF])) begin
            scanFlag_r <= 1'b0;                                       // R5
         end
         if (holdNow) begin
            pause_r <= 1'b1;                                          // R12 R13
         end else if (wrCtrlHi && !wb_dat_i[ASC_BIT_PAUSE_FLAG] && !dmaPending) begin
            pause_r <= 1'b0;                                          // R14
         end
      end
   end

   // Result storage and channel latch
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         result_r  <= ASC_RST_DATA;
         chLatch_r <= ASC_RST_CHAN;
      end else if (storeNow) begin
         result_r  <= storeVal;                                       // R22
         chLatch_r <= chPtr_r;                                        // R23
      end
   end

   // Per-channel result registers
   for (genvar ch = 0; ch < 32; ch++) begin : g_chdata
      always_ff @(posedge ref_clk) begin
         if (reset) begin
            chData_r[ch] <= ASC_RST_DATA;
         end else if (storeNow && (chPtr_r == 5'(ch))) begin
            chData_r[ch] <= storeVal;                                 // R22
         end
      end
   end

   // Request outputs steered by DMA activation
   assign convIrq    = convFlag_r & convIe_r & ~dmaCfg_r[ASC_BIT_DMA_CONV];     // R10
   assign convDmaReq = convFlag_r & convIe_r & dmaCfg_r[ASC_BIT_DMA_CONV];      // R10
   assign scanIrq    = scanFlag_r & scanIe_r & contMode
                       & ~dmaCfg_r[ASC_BIT_DMA_SCAN];                           // R4
   assign scanDmaReq = scanFlag_r & scanIe_r & contMode
                       & dmaCfg_r[ASC_BIT_DMA_SCAN];                            // R4

   // Read views; locked reads count as read-modify-write
   assign rmwRead   = wb_lock_i;
   assign achShown  = achMode_r ? chLatch_r : chPtr_r;               // R23 R24
   assign ctrlWord  = {busy_r | rmwRead, convFlag_r, convIe_r, pause_r, startSource_r,
                       1'b0, rsvd_r, opMode_r, res8_r, achShown};    // R7 R24
   assign stat2Word = {ctrlWord[15:12], 2'h0,                        // R1 R2
                       scanFlag_r | rmwRead, scanIe_r, 8'h00};       // R5

   // Read data register; unmapped words read zero
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         wb_dat_o <= 32'h0000_0000;
      end else if (rdEn) begin
         case (wb_adr_i)
            ASC_OFS_CTRL:   wb_dat_o <= {16'h0000, ctrlWord};
            ASC_OFS_STAT2:  wb_dat_o <= {16'h0000, stat2Word};
            ASC_OFS_CHSEL:  wb_dat_o <= {16'h0000, 3'h0, startCh_r, 3'h0, endCh_r};
            ASC_OFS_RESULT: wb_dat_o <= {22'h00_0000, result_r};
            ASC_OFS_DMACFG: wb_dat_o <= {30'h0000_0000, dmaCfg_r};
            default: begin
               if (wb_adr_i[7] && (wb_adr_i[1:0] == 2'h0)) begin
                  wb_dat_o <= {22'h00_0000, chData_r[wb_adr_i[6:2]]};
               end else begin
                  wb_dat_o <= 32'h0000_0000;
               end
            end
         endcase
      end
   end

   // Checks
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (reset);

   property p_mirror;
      rdEn && (wb_adr_i == ASC_OFS_STAT2) |=> wb_dat_o[15:12] == $past(ctrlWord[15:12]);
   endproperty
   a_mirror: assert property (p_mirror) else $error("status mirror mismatch"); // R1

   property p_gap;
      rdEn && (wb_adr_i == ASC_OFS_STAT2) |=> wb_dat_o[11:10] == 2'h0;
   endproperty
   a_gap: assert property (p_gap) else $error("unimplemented bits not zero"); // R2

   property p_scan_set;
      storeNow && stepLast |=> scanFlag_r && convFlag_r;
   endproperty
   a_scan_set: assert property (p_scan_set) else $error("scan flag not set"); // R3

   property p_force_stop;
      busyClr && (state_r != ST_IDLE) |=> (state_r == ST_IDLE) && !busy_r;
   endproperty
   a_force_stop: assert property (p_force_stop) else $error("forced stop failed"); // R8

   property p_hold;
      holdNow |=> (state_r == ST_HOLD) && pause_r && (result_r == $past(result_r));
   endproperty
   a_hold: assert property (p_hold) else $error("protected store not held"); // R11

   property p_store;
      storeNow |=> convFlag_r && (result_r == $past(storeVal));
   endproperty
   a_store: assert property (p_store) else $error("result store wrong"); // R10

   property p_single_end;
      storeNow && singleAny && stepLast && !activation |=> (state_r == ST_IDLE) && !busy_r;
   endproperty
   a_single_end: assert property (p_single_end) else $error("single run not ended"); // R7

   property p_latch;
      storeNow |=> chLatch_r == $past(chPtr_r);
   endproperty
   a_latch: assert property (p_latch) else $error("channel latch wrong"); // R23

   property p_pause_keep;
      pause_r && dmaPending && wrCtrlHi && !wb_dat_i[ASC_BIT_PAUSE_FLAG] |=> pause_r;
   endproperty
   a_pause_keep: assert property (p_pause_keep) else $error("pause cleared during DMA"); // R14

   property p_no_reactivate;
      (state_r == ST_CONV) && !single1 && activation && !busyClr && !convResult.valid
         |=> $stable(chPtr_r) && !launch_r;
   endproperty
   a_no_reactivate: assert property (p_no_reactivate) else $error("reactivation not ignored"); // R20
endmodule

// file: test/asc_conv_model.sv
// Behavioural converter that answers each start request after a random delay
`timescale 1ns/1ps
module asc_conv_model (
   input  wire logic                 ref_clk,
   input  wire logic                 reset,
   input  wire asc_pkg::asc_conv_req_s convReq,
   output asc_pkg::asc_result_s      convResult
);
   import asc_pkg::*;
   int         cnt;
   logic [4:0] ch;
   initial convResult = '0;
   // Result is the channel number twice; data line toggles while idle
   always @(posedge ref_clk) begin
      if (!reset && convReq.start) begin
         cnt <= 1 + $urandom_range(3);
         ch  <= convReq.chan;
      end else if (!reset && cnt > 0) begin
         cnt <= cnt - 1;
      end else begin
         cnt <= 0;
      end
      if (!reset && !convReq.start && cnt == 1) begin
         convResult <= {1'b1, ch, ch};
      end else begin
         convResult <= {1'b0, ~convResult.data};
      end
   end
endmodule

// file: test/asc_seq_ctrl_bench.sv
// Self-checking bench of the converter sequencer control block
`timescale 1ns/1ps
module asc_seq_ctrl_bench;
   import asc_pkg::*;
   logic          ref_clk = 1'b0;
   logic          reset   = 1'b1;
   logic          cyc = 1'b0, stb = 1'b0, we = 1'b0, extTrig = 1'b1;
   logic          lock = 1'b0, tmr = 1'b0, dmaWait = 1'b0, dmaEnd = 1'b0;
   logic [7:0]    adr = '0;
   logic [3:0]    sel = '0;
   logic [31:0]   dat = '0, q, wbDat;
   logic          wbAck, convIrq;
   asc_conv_req_s convReq;
   asc_result_s   convResult;
   int            n_mismatch = 0, checks_done = 0, ch, e8;
   initial forever #5 ref_clk = ~ref_clk;
   // Device under test and converter model
   asc_seq_ctrl i_dut (.ref_clk(ref_clk), .reset(reset), .wb_cyc_i(cyc), .wb_stb_i(stb),
      .wb_we_i(we), .wb_lock_i(lock), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat),
      .wb_dat_o(wbDat), .wb_ack_o(wbAck), .extTrigPin(extTrig), .reloadTimer7Out(tmr),
      .convReq(convReq), .convResult(convResult), .dmaConvDone(dmaEnd), .dmaScanDone(dmaEnd),
      .dmaPending(dmaWait), .convIrq(convIrq), .convDmaReq(), .scanIrq(), .scanDmaReq());
   asc_conv_model i_conv (.ref_clk(ref_clk), .reset(reset), .convReq(convReq),
      .convResult(convResult));
   // Expected common result for a channel and resolution
   function automatic logic [31:0] resExp(input int c, input int e);
      logic [9:0] d;
      d = {c[4:0], c[4:0]};
      return e ? {24'h0, d[9:2]} : {22'h0, d};
   endfunction
   task automatic report_and_stop();
      if (n_mismatch == 0 && checks_done > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp) begin
         n_mismatch++;
         $display("Error t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // Classic Wishbone cycle; read data lands in q
   task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int i;
      @(posedge ref_clk);
      {cyc, stb, we, adr, dat} <= {2'b11, w, a, d};
      sel <= 4'h3 | 4'($urandom);
      i = 0;
      do begin
         @(posedge ref_clk);
         i++;
      end while (wbAck !== 1'b1 && i < 20);
      q = wbDat;
      {cyc, stb} <= 2'b00;
      if (wbAck !== 1'b1) begin
         chk({31'h0, wbAck}, 32'h1);
         report_and_stop();
      end
   endtask
   // Bounded wait for a control bit
   task automatic poll(input int b, input logic v);
      int i;
      for (i = 0; i < 200; i++) begin
         wb(0, ASC_OFS_CTRL, 0);
         if (q[b] === v) break;
      end
      if (q[b] !== v) begin
         chk({31'h0, q[b]}, {31'h0, v});
         report_and_stop();
      end
   endtask
   initial begin
      void'($urandom(32'h4ec73920));
      repeat (5) @(posedge ref_clk);
      reset <= 1'b0;
      wb(0, ASC_OFS_CTRL, 0);
      chk(q, 32'h0);
      wb(1, ASC_OFS_STAT2, 32'hFC00);
      wb(0, ASC_OFS_STAT2, 0);
      chk(q, 32'h0);
      // Locked read counts as read-modify-write
      @(posedge ref_clk);
      lock <= 1'b1;
      wb(0, ASC_OFS_STAT2, 0);
      lock <= 1'b0;
      chk(q, 32'h8200);
      wb(0, 8'h40, 0);
      chk(q, 32'h0);
      // Single channel, random channel and resolution
      ch = $urandom_range(31);
      e8 = $urandom_range(1);
      wb(1, ASC_OFS_CHSEL, ch * 32'h0101);
      wb(1, ASC_OFS_CTRL, 32'hA200 | (e8 << 5));
      poll(ASC_BIT_INT, 1'b1);
      poll(ASC_BIT_BUSY, 1'b0);
      chk(q & 32'hFFE0, 32'h6000 | (e8 << 5));
      chk({31'h0, convIrq}, 32'h1);
      wb(0, ASC_OFS_STAT2, 0);
      chk(q & 32'hFF00, 32'h6200);
      wb(0, ASC_OFS_RESULT, 0);
      chk(q, resExp(ch, e8));
      wb(1, ASC_OFS_CTRL, 0);
      wb(1, ASC_OFS_STAT2, 0);
      // Second result withheld while the done flag is pending
      wb(1, ASC_OFS_CHSEL, 32'h0506);
      wb(1, ASC_OFS_CTRL, 32'h8200);
      poll(ASC_BIT_PAUSE_FLAG, 1'b1);
      chk(q & 32'hF000, 32'hD000);
      wb(0, ASC_OFS_RESULT, 0);
      chk(q, resExp(5, 0));
      // Pause survives a zero write while DMA waits
      dmaWait <= 1'b1;
      wb(1, ASC_OFS_CTRL, 32'hC000);
      dmaWait <= 1'b0;
      wb(0, ASC_OFS_CTRL, 0);
      chk(q & 32'hF000, 32'hD000);
      wb(1, ASC_OFS_CTRL, 0);
      wb(0, ASC_OFS_CTRL, 0);
      chk(q & 32'hF000, 32'h0);
      // Start from the external pin falling edge
      wb(1, ASC_OFS_CHSEL, 32'h0303);
      wb(1, ASC_OFS_CTRL, 32'h0400);
      @(posedge ref_clk);
      extTrig <= 1'b0;
      poll(ASC_BIT_INT, 1'b1);
      wb(0, ASC_OFS_RESULT, 0);
      chk(q, resExp(3, 0));
      // Start from the reload timer rising edge
      wb(1, ASC_OFS_CHSEL, 32'h0909);
      wb(1, ASC_OFS_CTRL, 32'h0800);
      tmr <= 1'b1;
      poll(ASC_BIT_INT, 1'b1);
      wb(0, ASC_OFS_RESULT, 0);
      chk(q, resExp(9, 0));
      // Stop mode: one channel per activation, busy stays set
      wb(1, ASC_OFS_CHSEL, 32'h0102);
      wb(1, ASC_OFS_CTRL, 32'h82C0);
      poll(ASC_BIT_INT, 1'b1);
      chk(q & 32'h80C0, 32'h80C0);
      wb(0, ASC_OFS_RESULT, 0);
      chk(q, resExp(1, 0));
      wb(1, ASC_OFS_CTRL, 32'h82C0);
      poll(ASC_BIT_INT, 1'b1);
      wb(0, ASC_OFS_RESULT, 0);
      chk(q, resExp(2, 0));
      // DMA end clears both flags
      @(posedge ref_clk);
      dmaEnd <= 1'b1;
      @(posedge ref_clk);
      dmaEnd <= 1'b0;
      wb(0, ASC_OFS_STAT2, 0);
      chk(q & 32'h4200, 32'h0);
      wb(1, ASC_OFS_CTRL, 0);
      wb(0, ASC_OFS_CTRL, 0);
      chk(q & 32'h8000, 32'h0);
      report_and_stop();
   end
endmodule
